// ==== common/sbac_pkg.sv ====
/*
 * Constants for the system bus arbitration and control block.
 * Assumes a single core clock; all bus pins are active low.
 */
package sbac_pkg;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_BPM = 32'h0000_0008;
    localparam logic [31:0] ADDR_AGENT = 32'h0000_000c;

    localparam int CTRL_REQ = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_STALL = 2;
    localparam int CTRL_ERR = 3;
    localparam int CTRL_DBG_RDY = 4;
    localparam int CTRL_DONE = 5;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [3:0] BPM_RESET = 4'h0;
    localparam logic [1:0] BSEL_RESET = 2'h0;

    // Power-on configuration straps are sampled during this many cycles
    localparam int CFG_CYCLES = 4;

    localparam logic [1:0] DEFAULT_BUS_FREQ_SELECT = 2'h0;

endpackage : sbac_pkg

// ==== hw/sbac_sync.sv ====
/*
 * Two flip-flop synchroniser for a vector of pin inputs.
 * Assumes synchronous active-low reset on the destination clock.
 */
`timescale 1ns/1ps
module sbac_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
        if (!rst_n) begin
            next_stage1 = INIT;
            next_dout = INIT;
        end
    end

    always_ff @(posedge clk) begin
        stage1 <= next_stage1;
        dout <= next_dout;
    end
endmodule : sbac_sync

// ==== hw/sbac_core.sv ====
/*
 * Processor-side bus arbitration and control: bus init, stall, priority
 * request, agent request, frequency select, breakpoint monitor pins,
 * with an APB register slave.
 * Assumes pins come from the bus clock domain and are synchronised here.
 */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Drive bus init on fatal error if enabled
// - Observed bus init resets lock, arbitration
// - Queue and tracking survive bus init
// - After bus init, re-arbitrate, finish queue
// - Assert block-next-request when unable to accept
// - No new transaction while stall active
// - Monitor pin four is probe ready
// - Monitor pin five is probe request
// - Priority request stops new unlocked requests
// - Request bus on agent request output
// - Sample request pin at configuration, agent 0
// - Drive two-bit frequency select outputs
// - All agents share one bus frequency
// - Drive and latch on bus clock; here all on CORE_CLK
module sbac_core #(
    parameter logic [1:0] BUS_FREQ_SELECT = sbac_pkg::DEFAULT_BUS_FREQ_SELECT,
    parameter int CFG_CYCLES = sbac_pkg::CFG_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [31:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BUS_INIT_N_IN,
    output logic BUS_INIT_N_OUT,
    output logic BUS_INIT_N_OE,
    input wire logic BLOCK_NEXT_REQ_N_IN,
    output logic BLOCK_NEXT_REQ_N_OUT,
    output logic BLOCK_NEXT_REQ_N_OE,
    input wire logic PRIORITY_BUS_REQ_N,
    input wire logic AGENT_BUS_REQ_N_IN,
    output logic AGENT_BUS_REQ_N_OUT,
    output logic AGENT_BUS_REQ_N_OE,
    input wire logic INIT_DRIVE_EN,
    input wire logic INIT_OBSERVE_EN,
    input wire logic PROBE_REQUEST_N,
    output logic [3:0] BRKPT_MONITOR_N,
    output logic PROBE_READY_N,
    output logic PROBE_REQ_SEEN,
    output logic [1:0] BUS_FREQ_SELECT_OUT
);

    typedef enum logic [3:0] {
        ARB_IDLE = 4'b0001,
        ARB_REQ = 4'b0010,
        ARB_OWN = 4'b0100,
        ARB_HOLD = 4'b1000
    } sbac_arb_t;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [6:0] pins_raw;
    logic [6:0] pins;
    logic init_in_n, bnr_in_n, priority_bus_req_n_n, br_in_n, probe_request_n_n;
    logic drive_strap, observe_strap;

    assign pins_raw = {INIT_OBSERVE_EN, INIT_DRIVE_EN, PROBE_REQUEST_N,
        AGENT_BUS_REQ_N_IN, PRIORITY_BUS_REQ_N, BLOCK_NEXT_REQ_N_IN,
        BUS_INIT_N_IN};
    assign {observe_strap, drive_strap, probe_request_n_n, br_in_n, priority_bus_req_n_n, bnr_in_n,
        init_in_n} = pins;

    sbac_sync #(.WIDTH(7), .INIT(7'h7f)) u_sync (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .din(pins_raw),
        .dout(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [3:0] monitor_n;
    logic [3:0] next_monitor_n;
    logic [7:0] cfg_cnt;
    logic [7:0] next_cfg_cnt;
    logic cfg_done;
    logic next_cfg_done;
    logic drive_en;
    logic next_drive_en;
    logic observe_en;
    logic next_observe_en;
    logic agent_zero;
    logic next_agent_zero;
    sbac_arb_t arb;
    sbac_arb_t next_arb;
    logic lock_active;
    logic next_lock_active;
    logic [7:0] queue_cnt;
    logic [7:0] next_queue_cnt;
    logic init_seen;
    logic next_init_seen;
    logic [7:0] init_cnt;
    logic [7:0] next_init_cnt;
    logic issued;
    logic next_issued;
    logic init_drive;
    logic next_init_drive;
    logic bnr_drive;
    logic next_bnr_drive;
    logic br_drive;
    logic next_br_drive;
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pready;
    logic next_pready;
    logic pslverr;
    logic next_pslverr;
    logic probe_ready_n;
    logic next_probe_ready_n;
    logic probe_request_n_seen;
    logic next_probe_request_n_seen;
    logic [1:0] bsel;
    logic [1:0] next_bsel;
    logic init_obs, stall, priority_hold, apb_access, ctrl_wr;

    function automatic logic addr_hit(input logic [31:0] a,
            input logic [31:0] r);
        addr_hit = (a[31:2] == r[31:2]);
    endfunction : addr_hit

    assign init_obs = observe_en && !init_in_n;
    assign stall = !bnr_in_n;
    assign priority_hold = !priority_bus_req_n_n && !lock_active;
    assign apb_access = PSEL && PENABLE && !pready;
    assign ctrl_wr = apb_access && PWRITE &&
        addr_hit(PADDR, sbac_pkg::ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // Configuration, arbitration and pin drive

    always_comb begin
        next_cfg_cnt = cfg_cnt;
        next_cfg_done = cfg_done;
        next_drive_en = drive_en;
        next_observe_en = observe_en;
        next_agent_zero = agent_zero;
        next_arb = arb;
        next_lock_active = ctrl[sbac_pkg::CTRL_LOCK];
        next_queue_cnt = queue_cnt;
        next_init_seen = init_seen;
        next_init_cnt = init_cnt;
        next_issued = 1'b0;
        next_init_drive = init_drive;
        next_bnr_drive = ctrl[sbac_pkg::CTRL_STALL];
        next_br_drive = 1'b0;
        next_probe_ready_n = !ctrl[sbac_pkg::CTRL_DBG_RDY];
        next_probe_request_n_seen = probe_request_n_seen || !probe_request_n_n;
        next_bsel = BUS_FREQ_SELECT;
        next_monitor_n = monitor_n;
        if (!cfg_done) begin
            next_cfg_cnt = cfg_cnt + 8'h01;
            next_drive_en = drive_strap;
            next_observe_en = observe_strap;
            next_agent_zero = !br_in_n;
            if (cfg_cnt == 8'(CFG_CYCLES - 1)) begin
                next_cfg_done = 1'b1;
            end
        end else begin
            if (ctrl[sbac_pkg::CTRL_ERR] && drive_en) begin
                next_init_drive = 1'b1;
            end else if (!ctrl[sbac_pkg::CTRL_ERR]) begin
                next_init_drive = 1'b0;
            end
            if (ctrl_wr && PWDATA[sbac_pkg::CTRL_REQ]) begin
                next_queue_cnt = queue_cnt + 8'h01;
            end
            if (ctrl_wr && PWDATA[sbac_pkg::CTRL_DONE] &&
                    queue_cnt != 8'h00) begin
                next_queue_cnt = next_queue_cnt - 8'h01;
            end
            if (init_obs) begin
                next_arb = ARB_IDLE;
                next_lock_active = 1'b0;
                next_init_seen = 1'b1;
                next_init_cnt = init_cnt + 8'h01;
            end else begin
                unique case (arb)
                    ARB_IDLE: begin
                        if (queue_cnt != 8'h00) begin
                            next_arb = ARB_REQ;
                        end
                    end
                    ARB_REQ: begin
                        next_br_drive = 1'b1;
                        if (priority_hold || stall) begin
                            next_arb = ARB_HOLD;
                        end else begin
                            next_arb = ARB_OWN;
                        end
                    end
                    ARB_OWN: begin
                        next_br_drive = 1'b1;
                        if (priority_hold || stall) begin
                            next_arb = ARB_HOLD;
                        end else begin
                            next_issued = 1'b1;
                            next_monitor_n = monitor_n - 4'h1;
                            if (queue_cnt <= 8'h01) begin
                                next_arb = ARB_IDLE;
                            end
                        end
                    end
                    ARB_HOLD: begin
                        next_br_drive = 1'b1;
                        if (!priority_hold && !stall) begin
                            next_arb = ARB_OWN;
                        end
                    end
                endcase
            end
        end
        if (!NRST) begin
            next_cfg_cnt = 8'h00;
            next_cfg_done = 1'b0;
            next_drive_en = 1'b0;
            next_observe_en = 1'b0;
            next_agent_zero = 1'b0;
            next_arb = ARB_IDLE;
            next_lock_active = 1'b0;
            next_queue_cnt = 8'h00;
            next_init_seen = 1'b0;
            next_init_cnt = 8'h00;
            next_issued = 1'b0;
            next_init_drive = 1'b0;
            next_bnr_drive = 1'b0;
            next_br_drive = 1'b0;
            next_probe_ready_n = 1'b1;
            next_probe_request_n_seen = 1'b0;
            next_bsel = sbac_pkg::BSEL_RESET;
            next_monitor_n = ~sbac_pkg::BPM_RESET;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        cfg_cnt <= next_cfg_cnt;
        cfg_done <= next_cfg_done;
        drive_en <= next_drive_en;
        observe_en <= next_observe_en;
        agent_zero <= next_agent_zero;
        arb <= next_arb;
        lock_active <= next_lock_active;
        queue_cnt <= next_queue_cnt;
        init_seen <= next_init_seen;
        init_cnt <= next_init_cnt;
        issued <= next_issued;
        init_drive <= next_init_drive;
        bnr_drive <= next_bnr_drive;
        br_drive <= next_br_drive;
        probe_ready_n <= next_probe_ready_n;
        probe_request_n_seen <= next_probe_request_n_seen;
        bsel <= next_bsel;
        monitor_n <= next_monitor_n;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, answers one cycle after the access phase starts

    always_comb begin
        next_ctrl = ctrl;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (apb_access) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            if (addr_hit(PADDR, sbac_pkg::ADDR_CTRL)) begin
                if (PWRITE) begin
                    next_ctrl = {26'h0, 1'b0, PWDATA[4:0]};
                end else begin
                    next_prdata = ctrl;
                end
            end else if (addr_hit(PADDR, sbac_pkg::ADDR_STATUS)) begin
                next_prdata = {init_cnt, queue_cnt, 8'h00,
                    arb, !priority_bus_req_n_n, stall, init_seen, issued};
            end else if (addr_hit(PADDR, sbac_pkg::ADDR_BPM)) begin
                next_prdata = {26'h0, probe_request_n_seen, !probe_ready_n, ~monitor_n};
            end else if (addr_hit(PADDR, sbac_pkg::ADDR_AGENT)) begin
                next_prdata = {27'h0, cfg_done, agent_zero, observe_en,
                    drive_en, 1'b0};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (!NRST) begin
            next_ctrl = sbac_pkg::CTRL_RESET;
            next_prdata = 32'h0000_0000;
            next_pready = 1'b0;
            next_pslverr = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        ctrl <= next_ctrl;
        prdata <= next_prdata;
        pready <= next_pready;
        pslverr <= next_pslverr;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; bus init, block-next-request and agent request open-drain style: drive low only when asserted

    assign PRDATA = prdata;
    assign PREADY = pready;
    assign PSLVERR = pslverr;
    assign BUS_INIT_N_OUT = 1'b0;
    assign BUS_INIT_N_OE = init_drive;
    assign BLOCK_NEXT_REQ_N_OUT = 1'b0;
    assign BLOCK_NEXT_REQ_N_OE = bnr_drive;
    assign AGENT_BUS_REQ_N_OUT = 1'b0;
    assign AGENT_BUS_REQ_N_OE = br_drive;
    assign BRKPT_MONITOR_N = monitor_n;
    assign PROBE_READY_N = probe_ready_n;
    assign PROBE_REQ_SEEN = probe_request_n_seen;
    assign BUS_FREQ_SELECT_OUT = bsel;

endmodule : sbac_core

// ==== verif/sbac_props.sv ====
/* Checker for the arbitration and control block ports.
   Assumes a bind onto sbac_core and a single clock domain. */
`timescale 1ns/1ps
module sbac_props #(
    parameter logic [1:0] BUS_FREQ_SELECT = 2'h0
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic BUS_INIT_N_OE,
    input wire logic BLOCK_NEXT_REQ_N_IN,
    input wire logic AGENT_BUS_REQ_N_OE,
    input wire logic INIT_DRIVE_EN,
    input wire logic PROBE_REQUEST_N,
    input wire logic [3:0] BRKPT_MONITOR_N,
    input wire logic PROBE_REQ_SEEN,
    input wire logic [1:0] BUS_FREQ_SELECT_OUT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    sequence access_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence stalled_s;
        !BLOCK_NEXT_REQ_N_IN [*5];
    endsequence
    sequence issue_s;
        $changed(BRKPT_MONITOR_N);
    endsequence
    apb_ready_a: assert property (access_s |=> PREADY)
        else $error("ready late");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    freq_select_a: assert property ($past(NRST) |->
        BUS_FREQ_SELECT_OUT == BUS_FREQ_SELECT) else $error("freq code");
    probe_seen_a: assert property (!PROBE_REQUEST_N |->
        ##[1:4] PROBE_REQ_SEEN) else $error("probe missed");
    probe_sticky_a: assert property (PROBE_REQ_SEEN |=>
        PROBE_REQ_SEEN) else $error("probe flag lost");
    stall_issue_a: assert property (stalled_s |=> not issue_s)
        else $error("issue in stall");
    agent_issue_a: assert property (issue_s |-> AGENT_BUS_REQ_N_OE ||
        $past(AGENT_BUS_REQ_N_OE) || $past(AGENT_BUS_REQ_N_OE, 2))
        else $error("issue without request");
    init_drive_a: assert property ($rose(BUS_INIT_N_OE) |->
        INIT_DRIVE_EN) else $error("init driven");
endmodule : sbac_props

// ==== verif/sbac_agents.sv ====
/* Far-side agents: chipset priority agent and other bus agents.
   Assumes pulled-up shared lines; low means asserted. */
`timescale 1ns/1ps
module sbac_agents (
    input wire logic clk,
    input wire logic cfg,
    input wire logic prio_go,
    input wire logic [7:0] prio_len,
    input wire logic stall,
    input wire logic init,
    input wire logic init_oe,
    input wire logic stall_oe,
    input wire logic ag_oe,
    output logic init_w,
    output logic stall_w,
    output logic ag_w,
    output logic prio_n
);
    logic [7:0] left = 8'h0;
    // Priority held for prio_len cycles after prio_go
    always @(posedge clk) begin
        if (prio_go) left <= prio_len;
        else if (left != 8'h0) left <= left - 8'h1;
    end
    assign prio_n = (left == 8'h0);
    assign init_w = !(init_oe || init);
    assign stall_w = !(stall_oe || stall);
    assign ag_w = !(ag_oe || cfg);
endmodule : sbac_agents

// ==== verif/tb.sv ====
/* Self-checking bench for sbac_core with the agent model.
   Assumes a one wait-state APB slave and pulled-up bus lines. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    failures++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, drv = 1'b1, obs = 1'b1, probe_request_n_n = 1'b1;
    logic cfg = 1'b1, prio_go = 1'b0, stall_r = 1'b0, init_r = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [31:0] seed = 32'hb5efab9e;
    logic [7:0] prio_len = 8'h0;
    logic [3:0] bpm, b0;
    logic [1:0] bsel;
    logic pready, pslverr, er, i_oe, i_out, s_oe, s_out, a_oe, a_out;
    logic prio_n, i_w, s_w, a_w, probe_ready_n_n, pseen;
    int failures = 0, comparisons = 0, q = 0, n;
    localparam logic [31:0] ctl = sbac_pkg::ADDR_CTRL;
    localparam logic [31:0] sts = sbac_pkg::ADDR_STATUS;
    localparam logic [31:0] m_req = 32'h1 << sbac_pkg::CTRL_REQ;
    localparam logic [31:0] m_stall = 32'h1 << sbac_pkg::CTRL_STALL;
    localparam logic [31:0] m_lock = 32'h1 << sbac_pkg::CTRL_LOCK;
    localparam logic [31:0] m_err = 32'h1 << sbac_pkg::CTRL_ERR;
    localparam logic [31:0] m_dbg = 32'h1 << sbac_pkg::CTRL_DBG_RDY;
    localparam logic [31:0] m_done = 32'h1 << sbac_pkg::CTRL_DONE;
    always #20 clk = ~clk;
    sbac_core #(.BUS_FREQ_SELECT(sbac_pkg::DEFAULT_BUS_FREQ_SELECT)) dut_u (
        .CORE_CLK(clk), .NRST(nrst), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BUS_INIT_N_IN(i_w), .BUS_INIT_N_OUT(i_out), .BUS_INIT_N_OE(i_oe),
        .BLOCK_NEXT_REQ_N_IN(s_w), .BLOCK_NEXT_REQ_N_OUT(s_out),
        .BLOCK_NEXT_REQ_N_OE(s_oe), .PRIORITY_BUS_REQ_N(prio_n),
        .AGENT_BUS_REQ_N_IN(a_w), .AGENT_BUS_REQ_N_OUT(a_out),
        .AGENT_BUS_REQ_N_OE(a_oe), .INIT_DRIVE_EN(drv),
        .INIT_OBSERVE_EN(obs), .PROBE_REQUEST_N(probe_request_n_n),
        .BRKPT_MONITOR_N(bpm), .PROBE_READY_N(probe_ready_n_n),
        .PROBE_REQ_SEEN(pseen), .BUS_FREQ_SELECT_OUT(bsel));
    sbac_agents agents_u (.clk(clk), .cfg(cfg), .prio_go(prio_go),
        .prio_len(prio_len), .stall(stall_r), .init(init_r),
        .init_oe(i_oe), .stall_oe(s_oe), .ag_oe(a_oe), .init_w(i_w),
        .stall_w(s_w), .ag_w(a_w), .prio_n(prio_n));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask : wt
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rst(input logic d, input logic o);
        nrst <= 1'b0;
        drv <= d;
        obs <= o;
        cfg <= 1'b1;
        wt(2);
        nrst <= 1'b1;
        wt(sbac_pkg::CFG_CYCLES + 4);
        cfg <= 1'b0;
        q = 0;
    endtask : rst
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        rst(1'b1, 1'b1);
        `CHK("freq", sbac_pkg::DEFAULT_BUS_FREQ_SELECT, bsel)
        `CHK("bpm", 4'hf, bpm)
        `CHK("probe_ready_n", 1'b1, probe_ready_n_n)
        `CHK("odlow", 3'h0, {i_out, s_out, a_out})
        apb(1'b0, sbac_pkg::ADDR_AGENT, 32'h0);
        `CHK("agent", 4'hf, rd[4:1])
        apb(1'b0, 32'h10, 32'h0);
        `CHK("slverr", 2'h1, {rd != 32'h0, er})
        probe_request_n_n <= 1'b0;
        wt(4);
        probe_request_n_n <= 1'b1;
        apb(1'b1, ctl, m_dbg);
        wt(2);
        `CHK("probe", 2'h1, {probe_ready_n_n, pseen})
        apb(1'b0, sbac_pkg::ADDR_BPM, 32'h0);
        `CHK("bpmreg", 2'h3, rd[5:4])
        prio_len <= 8'd60;
        prio_go <= 1'b1;
        wt(1);
        prio_go <= 1'b0;
        wt(5);
        b0 = bpm;
        n = xs() % 3 + 1;
        repeat (n) apb(1'b1, ctl, m_dbg | m_req);
        q += n;
        wt(5);
        `CHK("prio", b0, bpm)
        `CHK("agentoe", 1'b1, a_oe)
        apb(1'b0, sts, 32'h0);
        `CHK("queue", q[7:0], rd[23:16])
        `CHK("prioseen", 1'b1, rd[3])
        wt(60);
        `CHK("issue", 1'b1, bpm !== b0)
        apb(1'b1, ctl, m_dbg | m_done);
        q--;
        apb(1'b0, sts, 32'h0);
        `CHK("retire", q[7:0], rd[23:16])
        apb(1'b1, ctl, m_dbg | m_stall);
        wt(2);
        `CHK("stalloe", 1'b1, s_oe)
        wt(4);
        b0 = bpm;
        apb(1'b1, ctl, m_dbg | m_stall | m_req);
        q++;
        wt(8);
        `CHK("stall", b0, bpm)
        apb(1'b0, sts, 32'h0);
        `CHK("stallseen", 1'b1, rd[2])
        apb(1'b1, ctl, m_dbg);
        wt(12);
        `CHK("resume", 1'b1, bpm !== b0)
        apb(1'b1, ctl, m_err);
        wt(3);
        `CHK("initoe", 1'b1, i_oe)
        apb(1'b1, ctl, 32'h0);
        wt(3);
        b0 = bpm;
        wt(12);
        `CHK("rearb", 1'b1, bpm !== b0)
        apb(1'b0, sts, 32'h0);
        `CHK("initseen", 1'b1, rd[1] && rd[31:24] != 8'h0)
        `CHK("kept", q[7:0], rd[23:16])
        rst(1'b0, 1'b0);
        `CHK("preqrst", 1'b0, pseen)
        apb(1'b0, sbac_pkg::ADDR_AGENT, 32'h0);
        `CHK("agent2", 4'hc, rd[4:1])
        apb(1'b1, ctl, m_err);
        wt(4);
        `CHK("nodrive", 1'b0, i_oe)
        init_r <= 1'b1;
        wt(4);
        init_r <= 1'b0;
        apb(1'b0, sts, 32'h0);
        `CHK("noobs", 1'b0, rd[1])
        b0 = bpm;
        prio_len <= 8'd20;
        prio_go <= 1'b1;
        wt(1);
        prio_go <= 1'b0;
        wt(3);
        apb(1'b1, ctl, m_lock | m_req);
        wt(6);
        `CHK("locked", 1'b1, bpm !== b0)
        results();
    end
    initial begin
        wt(3000);
        failures++;
        results();
    end
endmodule : tb
bind sbac_core sbac_props #(.BUS_FREQ_SELECT(BUS_FREQ_SELECT)) chk_u (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .BUS_INIT_N_OE(BUS_INIT_N_OE),
    .BLOCK_NEXT_REQ_N_IN(BLOCK_NEXT_REQ_N_IN),
    .AGENT_BUS_REQ_N_OE(AGENT_BUS_REQ_N_OE), .INIT_DRIVE_EN(INIT_DRIVE_EN),
    .PROBE_REQUEST_N(PROBE_REQUEST_N), .BRKPT_MONITOR_N(BRKPT_MONITOR_N),
    .PROBE_REQ_SEEN(PROBE_REQ_SEEN),
    .BUS_FREQ_SELECT_OUT(BUS_FREQ_SELECT_OUT));
